// [pkg/port_m_pkg.sv]
package port_m_pkg;

  // Port geometry.
  localparam int unsigned PORT_WIDTH = 6;
  localparam int unsigned REG_WIDTH  = 8;

  // Word-aligned byte addresses on the register bus.
  localparam logic [3:0] ADDR_DATA      = 4'h0;
  localparam logic [3:0] ADDR_PIN_INPUT = 4'h4;
  localparam logic [3:0] ADDR_DIRECTION = 4'h8;
  localparam logic [3:0] ADDR_PERIPH_EN = 4'hc;

  // Pin positions of the shared functions.
  localparam int unsigned BIT_SPI_SS  = 3;
  localparam int unsigned BIT_SPI_MISO = 2;
  localparam int unsigned BIT_CAN_TX  = 1;
  localparam int unsigned BIT_CAN_RX  = 0;

  // Field positions in the peripheral enable register.
  localparam int unsigned EN_SPI_BIT = 0;
  localparam int unsigned EN_CAN_BIT = 1;

  // Reset values.
  localparam logic [5:0] DATA_RESET      = 6'h00;
  localparam logic [5:0] DIRECTION_RESET = 6'h00;
  localparam logic [1:0] PERIPH_EN_RESET = 2'h0;

  // Bus read data of an unmapped or reserved location.
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : port_m_pkg

// [core/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser for one vector of pin levels.
module pin_sync #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : pin_sync

`default_nettype wire

// [core/port_m_gpio.sv]
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module port_m_gpio (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Classic Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Pads.
  input  wire logic [5:0]  pad_i,
  output logic      [5:0]  pad_o,
  output logic      [5:0]  pad_oe_o,
  // SPI side of bits 3 and 2.
  input  wire logic        spi_ss_out_i,
  input  wire logic        spi_ss_oe_i,
  output logic             spi_ss_in_o,
  input  wire logic        spi_miso_out_i,
  input  wire logic        spi_miso_oe_i,
  output logic             spi_miso_in_o,
  // CAN side of bits 1 and 0.
  input  wire logic        can_transmit_pin_i,
  output logic             can_receive_pin_o
);

  logic [5:0] port_data_latch_reg;
  logic [5:0] port_direction_reg;
  logic [1:0] periph_en_reg;
  logic [5:0] port_pin_sample;
  logic [5:0] pad_next;
  logic [5:0] pad_oe_next;
  logic [5:0] data_view;
  logic       req;
  logic       spi_en;
  logic       can_en;
  logic [31:0] rd_next;

  assign req    = cyc_i & stb_i & ~ack_o;
  assign spi_en = periph_en_reg[port_m_pkg::EN_SPI_BIT];
  assign can_en = periph_en_reg[port_m_pkg::EN_CAN_BIT];

  // Pad levels are asynchronous, so they pass two flops before use.
  pin_sync #(
    .WIDTH (port_m_pkg::PORT_WIDTH)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (pad_i),
    .sync_o  (port_pin_sample)
  );

  // Acknowledge one cycle after the request, drop it the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // Data latch; only byte lane 0 carries the port.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_data_latch_reg <= port_m_pkg::DATA_RESET;
    end else if (req && we_i && sel_i[0] && adr_i == port_m_pkg::ADDR_DATA) begin
      port_data_latch_reg <= dat_i[5:0];
    end
  end

  // Direction bits are never touched by peripheral forcing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_direction_reg <= port_m_pkg::DIRECTION_RESET;
    end else if (req && we_i && sel_i[0] && adr_i == port_m_pkg::ADDR_DIRECTION) begin
      port_direction_reg <= dat_i[5:0];
    end
  end

  // Peripheral enables stand in for the SPI and CAN controllers' enables.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_en_reg <= port_m_pkg::PERIPH_EN_RESET;
    end else if (req && we_i && sel_i[0] && adr_i == port_m_pkg::ADDR_PERIPH_EN) begin
      periph_en_reg <= dat_i[1:0];
    end
  end

  // Data register view selects latch or pin per direction bit.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      data_view[i] = port_direction_reg[i] ? port_data_latch_reg[i]
                                           : port_pin_sample[i];
    end
  end

  // Read mux; writes to the pin input address decode to nothing.
  always_comb begin
    rd_next = port_m_pkg::READ_ZERO;
    unique case (adr_i)
      port_m_pkg::ADDR_DATA:      rd_next[5:0] = data_view;
      port_m_pkg::ADDR_PIN_INPUT: rd_next[5:0] = port_pin_sample;
      port_m_pkg::ADDR_DIRECTION: rd_next[5:0] = port_direction_reg;
      port_m_pkg::ADDR_PERIPH_EN: rd_next[1:0] = periph_en_reg;
      default:                    rd_next = port_m_pkg::READ_ZERO;
    endcase
  end

  // Read data is registered with the acknowledge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= port_m_pkg::READ_ZERO;
    end else if (req && !we_i) begin
      dat_o <= rd_next;
    end
  end

  // Pad ownership: peripheral first, then general purpose by direction.
  always_comb begin
    pad_next    = port_data_latch_reg;
    pad_oe_next = port_direction_reg;
    if (spi_en) begin
      pad_next[port_m_pkg::BIT_SPI_SS]     = spi_ss_out_i;
      pad_oe_next[port_m_pkg::BIT_SPI_SS]  = spi_ss_oe_i;
      pad_next[port_m_pkg::BIT_SPI_MISO]   = spi_miso_out_i;
      pad_oe_next[port_m_pkg::BIT_SPI_MISO] = spi_miso_oe_i;
    end
    if (can_en) begin
      pad_next[port_m_pkg::BIT_CAN_TX]    = can_transmit_pin_i;
      pad_oe_next[port_m_pkg::BIT_CAN_TX] = 1'b1;
      pad_next[port_m_pkg::BIT_CAN_RX]    = 1'b0;
      pad_oe_next[port_m_pkg::BIT_CAN_RX] = 1'b0;
    end
  end

  // Pad drivers are registered, costing one cycle of latency.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o    <= 6'h00;
      pad_oe_o <= 6'h00;
    end else begin
      pad_o    <= pad_next;
      pad_oe_o <= pad_oe_next;
    end
  end

  // Peripheral inputs see the synchronised pins; idle high if not enabled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spi_ss_in_o       <= 1'b1;
      spi_miso_in_o     <= 1'b1;
      can_receive_pin_o <= 1'b1;
    end else begin
      spi_ss_in_o       <= spi_en ? port_pin_sample[port_m_pkg::BIT_SPI_SS] : 1'b1;
      spi_miso_in_o     <= spi_en ? port_pin_sample[port_m_pkg::BIT_SPI_MISO] : 1'b1;
      can_receive_pin_o <= can_en ? port_pin_sample[port_m_pkg::BIT_CAN_RX] : 1'b1;
    end
  end

endmodule : port_m_gpio

`default_nettype wire

// [test/port_m_gpio_properties.sv]
`timescale 1ns/1ps
`default_nettype none

module port_m_gpio_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [5:0]  pad_i,
  input wire logic [5:0]  pad_o,
  input wire logic [5:0]  pad_oe_o
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic take = cyc_i && stb_i && !ack_o;

  ack_next_a: assert property (take |=> ack_o) else $error("ack late");
  ack_once_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  dat_hold_a: assert property ($changed(dat_o) |-> ack_o) else $error("read data moved");
  unmapped_zero_a: assert property (take && !we_i && adr_i == 4'h2 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  ro_write_a: assert property (take && we_i && adr_i == 4'h4 |=>
    ($stable(pad_o) && $stable(pad_oe_o)) [*2]) else $error("pin input write took effect");
  pad_cause_a: assert property ($changed({pad_o[5:4], pad_oe_o[5:4]}) |->
    ack_o || $past(ack_o)) else $error("pads moved without write");
  pin_read_a: assert property (($stable(pad_i) [*4] ##0 (take && !we_i && adr_i == 4'h4)) |=>
    dat_o == {26'h0, $past(pad_i)}) else $error("pin input read wrong");

  write_c: cover property (take && we_i);
  pin_c: cover property (take && !we_i && adr_i == 4'h4);
  drive_c: cover property ($rose(pad_oe_o[5]));
endmodule : port_m_gpio_properties

bind port_m_gpio port_m_gpio_properties chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .dat_o, .ack_o, .pad_i, .pad_o, .pad_oe_o);

`default_nettype wire

// [test/pin_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Board side of the six pins; a short pulls a pin low even while it is driven.
module pin_model (
  input  wire logic [5:0] drv_i,
  input  wire logic [5:0] oe_i,
  input  wire logic [5:0] ext_i,
  input  wire logic [5:0] short_i,
  output logic      [5:0] level_o
);
  assign level_o = (drv_i & oe_i | ext_i & ~oe_i) & ~short_i;
endmodule : pin_model

`default_nettype wire

// [test/port_m_gpio_test.sv]
`timescale 1ns/1ps
`default_nettype none

module port_m_gpio_test;
  logic        clk_i = '0, rst_i = '1, cyc_i = '0, stb_i = '0, we_i = '0, ack_o;
  logic [3:0]  adr_i = '0, sel_i = 4'hf;
  logic [31:0] dat_i = '0, dat_o;
  logic [5:0]  pad_i, pad_o, pad_oe_o, ext = '0, short = '0;
  logic        ss_i, miso_i, can_receive_pin_o, ss_out = '0, ss_oe = '0, tx = '0;
  int          n_fail = 0, samples_checked = 0;

  // The clock runs free at 25 MHz.
  always #20 clk_i = ~clk_i;

  port_m_gpio dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .pad_i, .pad_o, .pad_oe_o, .spi_ss_out_i(ss_out), .spi_ss_oe_i(ss_oe),
    .spi_ss_in_o(ss_i), .spi_miso_out_i(1'b0), .spi_miso_oe_i(1'b0), .spi_miso_in_o(miso_i),
    .can_transmit_pin_i(tx), .can_receive_pin_o);
  pin_model pins (.drv_i(pad_o), .oe_i(pad_oe_o), .ext_i(ext), .short_i(short), .level_o(pad_i));

  task automatic test_done;
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask : chk

  // One Wishbone cycle; d is the write data or the expected read data.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      test_done();
    end
    if (!w) chk(dat_o, d);
    {cyc_i, stb_i} <= 2'b00;
  endtask : bus

  // Lets pad registers and the two-stage input synchroniser catch up.
  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask : settle

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, 4'h8, 32'h0);
    bus(0, 4'h2, 32'h0);
    bus(1, 4'h8, 32'h3f);
    bus(1, 4'h0, 32'h2a);
    settle();
    chk(32'({pad_oe_o, pad_o}), 32'hfea);
    short <= 6'h02;
    settle();
    bus(0, 4'h4, 32'h28);
    bus(0, 4'h0, 32'h2a);
    bus(1, 4'h8, 32'h0);
    ext <= 6'h15;
    settle();
    bus(0, 4'h0, 32'h15);
    bus(1, 4'h4, 32'h3f);
    bus(0, 4'h4, 32'h15);
    bus(1, 4'h8, 32'h3f);
    tx <= 1'b0;
    bus(1, 4'hc, 32'h2);
    settle();
    chk(32'({can_receive_pin_o, pad_o[1], pad_oe_o[1:0]}), 32'ha);
    bus(0, 4'h8, 32'h3f);
    {ss_oe, ss_out} <= 2'b10;
    bus(1, 4'hc, 32'h1);
    settle();
    chk(32'({ss_i, miso_i, pad_o[3], pad_oe_o[3:2]}), 32'ha);
    bus(0, 4'h8, 32'h3f);
    test_done();
  end
endmodule : port_m_gpio_test

`default_nettype wire
